/* core/pad_function_selector.sv */
// Pad function selector for pins two to eight: control words, pad routing to
// the general port, PWM, LIN, UART, SPI and the test mux.
// Assumes pad inputs synchronous to core_clk and a single-cycle register port.
//
// Functional notes
// - Bit three low connects pull-up; resets off.
// - Bit four high connects pull-down; resets zero.
// - Bit five enables pad input read path.
// - Mode zero: general port drives, direction enables.
// - Pad n maps to port bit n-1.
// - Mode one outputs per-pad PWM channel.
// - Test-mux outputs need debug access on pin two code five and pins three, six, seven code two only.
// - Pad two alternate source codes.
// - Pad three alternate source codes.
// - LIN single-wire: shared pad, open-drain transmit.
// - Pad four alternate source codes.
// - Pad five alternate source codes.
// - Pad five bit eight: idle transmit direction.
// - Pad six bit six forces receive idle.
// - Pad six alternate source codes.
// - Pad seven alternate source codes.
//
// Local design decision: the strobed register port.
`default_nettype none
module pad_function_selector
    import pad_mux_pkg::*;
#(
    parameter int PADS = NUM_PADS
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic sys_rst,
    // Register port.
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWrStrobe,
    input wire logic regRdStrobe,
    output logic [DATA_W-1:0] regRdData,
    // Pads, index zero is pin two.
    input wire logic [NUM_PADS-1:0] padIn,
    output logic [NUM_PADS-1:0] padOut,
    output logic [NUM_PADS-1:0] padOeN,
    output logic [NUM_PADS-1:0] padPullUpOn,
    output logic [NUM_PADS-1:0] padPullDownOn,
    output logic [NUM_PADS-1:0] padReadOn,
    // General port bits one to seven.
    input wire logic [NUM_PADS-1:0] generalPortBitOut,
    input wire logic [NUM_PADS-1:0] generalPortBitDir,
    output logic [NUM_PADS-1:0] generalPortBitIn,
    // PWM channels one to four and debug access.
    input wire logic [PWM_CHANNELS-1:0] pwmChannel,
    input wire logic debugAccessOn,
    // LIN master controller.
    input wire logic linMasterTxd,
    input wire logic linMasterCoreRxd,
    input wire logic linMasterFilt1In,
    input wire logic linMasterFilt1Out,
    input wire logic linMasterFilt2Out,
    output logic linMasterReceive,
    output logic linMasterTxdTest,
    // LIN slave controller.
    input wire logic linSlaveTxd,
    input wire logic linSlaveCoreRxd,
    input wire logic linSlaveFilt1In,
    input wire logic linSlaveFilt1Out,
    input wire logic linSlaveFilt2Out,
    output logic linSlaveReceive,
    output logic linSlaveTxdTest,
    // UART.
    input wire logic uartTxd,
    input wire logic uartTxBusy,
    output logic uartRxd,
    output logic uartTxdFromPad,
    // SPI master.
    input wire logic spiSelect,
    input wire logic spiClock,
    input wire logic spiMosi,
    output logic spiMiso
);

    // Registered state: control words and every top-level output.
    typedef struct packed {
        logic [NUM_PADS-1:0][CTRL_W-1:0] ctrl;
        logic [DATA_W-1:0] rdData;
        logic [NUM_PADS-1:0] padOut;
        logic [NUM_PADS-1:0] padOeN;
        logic [NUM_PADS-1:0] pullUpOn;
        logic [NUM_PADS-1:0] pullDownOn;
        logic [NUM_PADS-1:0] readOn;
        logic [NUM_PADS-1:0] gpIn;
        logic lmRx;
        logic lmTxTest;
        logic lsRx;
        logic lsTxTest;
        logic uartRx;
        logic uartTxIn;
        logic miso;
    } state_t;

    state_t st_q;
    state_t st_d;

    // Only the seven-pad map exists in the register decode.
    if (PADS != NUM_PADS) begin : g_chk
        $error("pad_function_selector supports exactly seven pads");
    end

    // Writable bits of each pad's word; all others stay zero.
    function automatic logic [CTRL_W-1:0] padMask(input int idx);
        if (idx == IDX_PIN5) begin
            return MASK_PIN5;
        end else if (idx == IDX_PIN6) begin
            return MASK_PIN6;
        end
        return MASK_COMMON;
    endfunction

    function automatic logic [2:0] padSourceSelect(input logic [CTRL_W-1:0] word);
        return word[MODE_MSB:MODE_LSB];
    endfunction

    // Next-state logic: register access first, then pad routing from the held words.
    always_comb begin
        logic [2:0] md;
        logic pin;
        logic uartRxRaw;
        md = SRC_GP;
        pin = 1'b0;
        uartRxRaw = 1'b1;
        st_d = st_q;
        st_d.rdData = '0;
        for (int i = 0; i < NUM_PADS; i++) begin
            if (regWrStrobe && regAddr == PAD_ADDR[i]) begin
                st_d.ctrl[i] = regWrData[CTRL_W-1:0] & padMask(i);
            end
            if (regRdStrobe && regAddr == PAD_ADDR[i]) begin
                st_d.rdData = {{(DATA_W-CTRL_W){1'b0}}, st_q.ctrl[i]};
            end
        end
        // Undefined codes fall through with the pad released and inputs idle.
        st_d.padOut = '0;
        st_d.padOeN = '1;
        st_d.gpIn = '0;
        st_d.lmRx = 1'b1;
        st_d.lsRx = 1'b1;
        st_d.lmTxTest = 1'b1;
        st_d.lsTxTest = 1'b1;
        st_d.uartTxIn = 1'b1;
        st_d.miso = 1'b0;
        for (int i = 0; i < NUM_PADS; i++) begin
            md = padSourceSelect(st_q.ctrl[i]);
            pin = padIn[i] & st_q.ctrl[i][INPUT_PATH_BIT];
            st_d.pullUpOn[i] = ~st_q.ctrl[i][PULLUP_DIS_N_BIT];
            st_d.pullDownOn[i] = st_q.ctrl[i][PULLDOWN_BIT];
            st_d.readOn[i] = st_q.ctrl[i][INPUT_PATH_BIT];
            if (md == SRC_GP) begin
                st_d.padOut[i] = generalPortBitOut[i];
                st_d.padOeN[i] = ~generalPortBitDir[i];
                st_d.gpIn[i] = pin;
            end else if (md == SRC_PWM) begin
                st_d.padOut[i] = pwmChannel[PWM_CH[i]];
                st_d.padOeN[i] = 1'b0;
            end else begin
                case (i)
                    0: begin
                        case (md)
                            SRC_ALT2: begin
                                if (debugAccessOn) begin
                                    st_d.lsTxTest = st_d.lsTxTest & pin;
                                end
                            end
                            SRC_ALT3: begin
                                st_d.padOut[i] = linMasterTxd;
                                st_d.padOeN[i] = 1'b0;
                            end
                            SRC_ALT4: begin
                                st_d.padOut[i] = spiSelect;
                                st_d.padOeN[i] = 1'b0;
                            end
                            SRC_ALT5: begin
                                st_d.padOut[i] = linSlaveFilt1Out;
                                st_d.padOeN[i] = ~debugAccessOn;
                            end
                            SRC_ALT6: begin
                                st_d.padOut[i] = linSlaveFilt1In;
                                st_d.padOeN[i] = 1'b0;
                            end
                            default: begin
                            end
                        endcase
                    end
                    1, 5: begin
                        case (md)
                            SRC_ALT2: begin
                                st_d.padOut[i] = (i == 1) ? linMasterCoreRxd : linMasterFilt2Out;
                                st_d.padOeN[i] = ~debugAccessOn;
                            end
                            SRC_ALT3: begin
                                st_d.lsRx = st_d.lsRx & pin;
                            end
                            SRC_ALT4: begin
                                // Single wire: drive low only, the bus pull-up makes the high.
                                st_d.lsRx = st_d.lsRx & pin;
                                st_d.padOut[i] = 1'b0;
                                st_d.padOeN[i] = linSlaveTxd;
                            end
                            SRC_ALT5: begin
                                st_d.padOut[i] = spiClock;
                                st_d.padOeN[i] = 1'b0;
                            end
                            SRC_ALT6: begin
                                if (i == 1) begin
                                    st_d.padOut[i] = linSlaveFilt1Out;
                                    st_d.padOeN[i] = 1'b0;
                                end else begin
                                    st_d.uartTxIn = st_d.uartTxIn & pin;
                                end
                            end
                            SRC_ALT7: begin
                                if (i == 1) begin
                                    st_d.padOut[i] = linMasterFilt1Out;
                                    st_d.padOeN[i] = 1'b0;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                    2, 6: begin
                        case (md)
                            SRC_ALT2: begin
                                uartRxRaw = uartRxRaw & pin;
                            end
                            SRC_ALT3: begin
                                // Shared wire: transmit owns the pad only while a frame is sent.
                                uartRxRaw = uartRxRaw & pin;
                                st_d.padOut[i] = uartTxd;
                                st_d.padOeN[i] = ~uartTxBusy;
                            end
                            SRC_ALT4: begin
                                st_d.padOut[i] = spiMosi;
                                st_d.padOeN[i] = 1'b0;
                            end
                            SRC_ALT5: begin
                                if (i == 2) begin
                                    if (debugAccessOn) begin
                                        st_d.lmTxTest = st_d.lmTxTest & pin;
                                    end
                                end else begin
                                    st_d.padOut[i] = linSlaveCoreRxd;
                                    st_d.padOeN[i] = 1'b0;
                                end
                            end
                            SRC_ALT6: begin
                                st_d.padOut[i] = (i == 2) ? linSlaveCoreRxd : linMasterCoreRxd;
                                st_d.padOeN[i] = 1'b0;
                            end
                            SRC_ALT7: begin
                                if (i == 2) begin
                                    st_d.padOut[i] = linMasterCoreRxd;
                                    st_d.padOeN[i] = 1'b0;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                    3: begin
                        case (md)
                            SRC_ALT2: begin
                                st_d.padOut[i] = uartTxd;
                                // Idle release lets a shared line be read between frames.
                                st_d.padOeN[i] = st_q.ctrl[i][TX_IDLE_DIR_BIT] & ~uartTxBusy;
                            end
                            SRC_ALT3: begin
                                st_d.padOut[i] = linSlaveTxd;
                                st_d.padOeN[i] = 1'b0;
                            end
                            SRC_ALT4: begin
                                st_d.miso = st_d.miso | pin;
                            end
                            SRC_ALT5: begin
                                st_d.padOut[i] = linMasterFilt1In;
                                st_d.padOeN[i] = 1'b0;
                            end
                            SRC_ALT6: begin
                                st_d.padOut[i] = linSlaveFilt1Out;
                                st_d.padOeN[i] = 1'b0;
                            end
                            SRC_ALT7: begin
                                st_d.padOut[i] = linMasterFilt1Out;
                                st_d.padOeN[i] = 1'b0;
                            end
                            default: begin
                            end
                        endcase
                    end
                    4: begin
                        case (md)
                            SRC_ALT2: begin
                                st_d.padOut[i] = linSlaveFilt2Out;
                                st_d.padOeN[i] = ~debugAccessOn;
                            end
                            SRC_ALT3: begin
                                st_d.padOut[i] = linMasterTxd;
                                st_d.padOeN[i] = 1'b0;
                            end
                            SRC_ALT4: begin
                                st_d.miso = st_d.miso | pin;
                            end
                            SRC_ALT5: begin
                                // Registered copy avoids a loop through the pad.
                                st_d.padOut[i] = st_q.uartRx;
                                st_d.padOeN[i] = 1'b0;
                            end
                            SRC_ALT6: begin
                                st_d.padOut[i] = linSlaveFilt2Out;
                                st_d.padOeN[i] = 1'b0;
                            end
                            SRC_ALT7: begin
                                st_d.padOut[i] = linMasterFilt2Out;
                                st_d.padOeN[i] = 1'b0;
                            end
                            default: begin
                            end
                        endcase
                    end
                    default: begin
                    end
                endcase
            end
        end
        st_d.lmRx = 1'b1;
        // The receive switch overrides every pad source, so a noisy line can be muted.
        st_d.uartRx = uartRxRaw | st_q.ctrl[IDX_PIN6][RX_FORCE_IDLE_BIT];
    end

    // One register stage for the whole state.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
            st_q.ctrl <= {NUM_PADS{CTRL_RESET}};
            st_q.padOeN <= '1;
            st_q.pullUpOn <= '0;
            st_q.lmRx <= 1'b1;
            st_q.lsRx <= 1'b1;
            st_q.lmTxTest <= 1'b1;
            st_q.lsTxTest <= 1'b1;
            st_q.uartRx <= 1'b1;
            st_q.uartTxIn <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state flip-flops.
    assign regRdData = st_q.rdData;
    assign padOut = st_q.padOut;
    assign padOeN = st_q.padOeN;
    assign padPullUpOn = st_q.pullUpOn;
    assign padPullDownOn = st_q.pullDownOn;
    assign padReadOn = st_q.readOn;
    assign generalPortBitIn = st_q.gpIn;
    assign linMasterReceive = st_q.lmRx;
    assign linMasterTxdTest = st_q.lmTxTest;
    assign linSlaveReceive = st_q.lsRx;
    assign linSlaveTxdTest = st_q.lsTxTest;
    assign uartRxd = st_q.uartRx;
    assign uartTxdFromPad = st_q.uartTxIn;
    assign spiMiso = st_q.miso;

    // Checks on the routing and the register port.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_pullup_pins: assert property (
        ##1 padPullUpOn[0] == ~$past(st_q.ctrl[0][PULLUP_DIS_N_BIT]))
        else $error("pull-up does not follow control bit");
    a_pulldown_pins: assert property (
        ##1 padPullDownOn[6] == $past(st_q.ctrl[6][PULLDOWN_BIT]))
        else $error("pull-down does not follow control bit");
    a_read_path_gate: assert property (
        st_q.ctrl[1][MODE_MSB:MODE_LSB] == SRC_GP && !st_q.ctrl[1][INPUT_PATH_BIT] |=> generalPortBitIn[1] == 1'b0)
        else $error("read path not gated");
    a_gp_drive_map: assert property (
        st_q.ctrl[2][MODE_MSB:MODE_LSB] == SRC_GP |=> padOut[2] == $past(generalPortBitOut[2])
            && padOeN[2] == ~$past(generalPortBitDir[2]))
        else $error("general port not routed to pad");
    a_pwm_channel_map: assert property (
        st_q.ctrl[4][MODE_MSB:MODE_LSB] == SRC_PWM |=> padOut[4] == $past(pwmChannel[0]) && !padOeN[4])
        else $error("wrong PWM channel on pad six");
    a_testmux_gated: assert property (
        st_q.ctrl[5][MODE_MSB:MODE_LSB] == SRC_ALT2 && !debugAccessOn |=> padOeN[5])
        else $error("test mux drives without debug access");
    a_single_wire_od: assert property (
        st_q.ctrl[1][MODE_MSB:MODE_LSB] == SRC_ALT4 |=> padOut[1] == 1'b0 && padOeN[1] == $past(linSlaveTxd))
        else $error("single-wire pad not open-drain");
    a_tx_idle_dir: assert property (
        st_q.ctrl[3] == (MASK_PIN5 & 9'h10a) && !uartTxBusy |=> padOeN[3])
        else $error("idle transmit pad not released");
    a_rx_force_idle: assert property (
        st_q.ctrl[IDX_PIN6][RX_FORCE_IDLE_BIT] |=> uartRxd)
        else $error("receive not forced idle");
    a_undefined_code: assert property (
        st_q.ctrl[5][MODE_MSB:MODE_LSB] == SRC_ALT7 |=> padOeN[5])
        else $error("undefined code drives pad seven");
    a_reserved_read: assert property (
        regRdStrobe |=> regRdData[DATA_W-1:TX_IDLE_DIR_BIT+1] == '0 && regRdData[7] == 1'b0)
        else $error("reserved bits read nonzero");
    a_read_one_cycle: assert property (
        !regRdStrobe |=> regRdData == '0)
        else $error("read data outside its cycle");

    c_write_then_read: cover property (regWrStrobe ##1 regRdStrobe ##1 regRdData != '0);
    c_single_wire: cover property (st_q.ctrl[5][MODE_MSB:MODE_LSB] == SRC_ALT4 ##1 !padOeN[5]);
    c_pwm_drive: cover property (st_q.ctrl[0][MODE_MSB:MODE_LSB] == SRC_PWM ##1 padOut[0]);
endmodule
`default_nettype wire

/* core/pad_mux_pkg.sv */
// Constants shared by the pad function selector: register map, field layout,
// reset values and source-select codes.
// Assumes a 32-bit byte address bus and seven pads, pins two to eight.
`default_nettype none
package pad_mux_pkg;
    localparam int NUM_PADS = 7;
    localparam int CTRL_W = 9;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;

    // Byte addresses of the pad control words, pin two first.
    localparam logic [ADDR_W-1:0] PIN2_PAD_CONTROL = 32'h5001_2004;
    localparam logic [ADDR_W-1:0] PIN3_PAD_CONTROL = 32'h5001_2008;
    localparam logic [ADDR_W-1:0] PIN4_PAD_CONTROL = 32'h5001_200c;
    localparam logic [ADDR_W-1:0] PIN5_PAD_CONTROL = 32'h5001_2010;
    localparam logic [ADDR_W-1:0] PIN6_PAD_CONTROL = 32'h5001_2014;
    localparam logic [ADDR_W-1:0] PIN7_PAD_CONTROL = 32'h5001_2018;
    localparam logic [ADDR_W-1:0] PIN8_PAD_CONTROL = 32'h5001_201c;
    localparam logic [ADDR_W-1:0] PAD_ADDR [NUM_PADS] = '{PIN2_PAD_CONTROL, PIN3_PAD_CONTROL,
        PIN4_PAD_CONTROL, PIN5_PAD_CONTROL, PIN6_PAD_CONTROL, PIN7_PAD_CONTROL, PIN8_PAD_CONTROL};

    // Field positions inside a control word.
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 2;
    localparam int PULLUP_DIS_N_BIT = 3;
    localparam int PULLDOWN_BIT = 4;
    localparam int INPUT_PATH_BIT = 5;
    localparam int RX_FORCE_IDLE_BIT = 6;
    localparam int TX_IDLE_DIR_BIT = 8;

    // Reset value: pull-up disconnected, everything else clear.
    localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h008;
    // Writable bits: the common fields, plus one extra bit on pads five and six.
    localparam logic [CTRL_W-1:0] MASK_COMMON = 9'h03f;
    localparam logic [CTRL_W-1:0] MASK_PIN5 = 9'h13f;
    localparam logic [CTRL_W-1:0] MASK_PIN6 = 9'h07f;
    localparam int IDX_PIN5 = 3;
    localparam int IDX_PIN6 = 4;

    // Source-select codes; codes two to seven mean something different per pad.
    localparam logic [2:0] SRC_GP = 3'h0;
    localparam logic [2:0] SRC_PWM = 3'h1;
    localparam logic [2:0] SRC_ALT2 = 3'h2;
    localparam logic [2:0] SRC_ALT3 = 3'h3;
    localparam logic [2:0] SRC_ALT4 = 3'h4;
    localparam logic [2:0] SRC_ALT5 = 3'h5;
    localparam logic [2:0] SRC_ALT6 = 3'h6;
    localparam logic [2:0] SRC_ALT7 = 3'h7;

    // PWM channel index (channel minus one) used by each pad in PWM mode.
    localparam int PWM_CH [NUM_PADS] = '{0, 1, 2, 3, 0, 1, 2};
    localparam int PWM_CHANNELS = 4;
endpackage
`default_nettype wire

/* testbench/pad_function_selector_tb.sv */
// Self-checking bench for the pad function selector.
// Assumes a 25 MHz core clock and the pad partner model on the pads.
`default_nettype none
module pad_function_selector_tb;
    import pad_mux_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, sys_rst = 1, regWrStrobe = 0, regRdStrobe = 0, dbg = 0;
    logic [31:0] regAddr = '0, regWrData = '0, regRdData, rdv;
    logic [6:0] padIn, padOut, padOeN, pullUp, pullDown, readOn, gpIn;
    logic [6:0] gpOut = '0, gpDir = '0, extLevel = '0, extOn = '0;
    logic [3:0] pwm = '0;
    logic mTxd = 1, sTxd = 1, uTxd = 1, uBusy = 0, spiS = 1, spiC = 0, spiM = 0, fil = 1;
    logic mRecv, mTest, sRecv, sTest, uRxd, uFromPad, miso;
    int fail_count = 0, total_checks = 0;
    always #20 core_clk = ~core_clk;
    pad_function_selector u_pad_function_selector (.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
        .padIn(padIn), .padOut(padOut), .padOeN(padOeN), .padPullUpOn(pullUp), .padPullDownOn(pullDown),
        .padReadOn(readOn), .generalPortBitOut(gpOut), .generalPortBitDir(gpDir), .generalPortBitIn(gpIn),
        .pwmChannel(pwm), .debugAccessOn(dbg), .linMasterTxd(mTxd), .linMasterCoreRxd(fil),
        .linMasterFilt1In(fil), .linMasterFilt1Out(fil), .linMasterFilt2Out(fil), .linMasterReceive(mRecv),
        .linMasterTxdTest(mTest), .linSlaveTxd(sTxd), .linSlaveCoreRxd(fil), .linSlaveFilt1In(fil),
        .linSlaveFilt1Out(fil), .linSlaveFilt2Out(fil), .linSlaveReceive(sRecv), .linSlaveTxdTest(sTest),
        .uartTxd(uTxd), .uartTxBusy(uBusy), .uartRxd(uRxd), .uartTxdFromPad(uFromPad),
        .spiSelect(spiS), .spiClock(spiC), .spiMosi(spiM), .spiMiso(miso));
    pad_partner u_pad_partner (.clk(core_clk), .padOut(padOut), .padOeN(padOeN), .padPullUpOn(pullUp),
        .padPullDownOn(pullDown), .extLevel(extLevel), .extOn(extOn), .padIn(padIn));
    // Verdict and end of run; a timeout lands here as well.
    task automatic close_out;
        if (fail_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus cycles; strobes are one cycle long and read data is taken one cycle later.
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWrStrobe <= 1;
        regAddr <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWrStrobe <= 0;
    endtask
    task automatic rd(input logic [31:0] a);
        @(posedge core_clk);
        regRdStrobe <= 1;
        regAddr <= a;
        @(posedge core_clk);
        regRdStrobe <= 0;
        #1 rdv = regRdData;
    endtask
    // Control words reach the pads one cycle after the write edge and the pad inputs one cycle later, so three is safe.
    task automatic settle;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task automatic t_reset;
        for (int i = 0; i < 7; i++) begin
            rd(PAD_ADDR[i]);
            chk(rdv, 32'h0000_0008);
        end
        rd(32'h5001_2000);
        chk(rdv, 32'h0000_0000);
        chk({4'h0, pullUp, pullDown, readOn, padOeN}, 32'h0000_007f);
    endtask
    task automatic t_mask;
        for (int i = 0; i < 7; i++) begin
            wr(PAD_ADDR[i], 32'hffff_ffff);
            rd(PAD_ADDR[i]);
            chk(rdv, i == 3 ? 32'h0000_013f : i == 4 ? 32'h0000_007f : 32'h0000_003f);
        end
        settle();
        chk({11'h0, pullUp, pullDown, readOn}, 32'h0000_3fff);
        chk(32'(padOeN[0]), 32'h1);
    endtask
    task automatic t_port;
        for (int i = 0; i < 7; i++) wr(PAD_ADDR[i], 32'h0000_0020);
        gpDir <= 7'h55;
        gpOut <= 7'h33;
        extOn <= 7'h2a;
        extLevel <= 7'h7f;
        settle();
        chk(32'(padOut & 7'h55), 32'h11);
        chk(32'(padOeN), 32'h2a);
        chk(32'(pullUp), 32'h7f);
        chk(32'(gpIn), 32'h3b);
    endtask
    task automatic t_pwm;
        for (int i = 0; i < 7; i++) wr(PAD_ADDR[i], 32'h0000_0021);
        pwm <= 4'b0110;
        settle();
        chk({18'h0, padOeN, padOut}, 32'h0000_0066);
    endtask
    task automatic t_mux;
        extOn <= 7'h01;
        extLevel <= 7'h00;
        fil <= 0;
        wr(PIN2_PAD_CONTROL, 32'h0000_0025);
        settle();
        chk(32'(padOeN[0]), 32'h1);
        dbg <= 1;
        settle();
        chk({padOeN[0], padOut[0]}, 32'h0);
        wr(PIN2_PAD_CONTROL, 32'h0000_0022);
        settle();
        chk(32'(sTest), 32'h0);
        dbg <= 0;
        settle();
        chk(32'(sTest), 32'h1);
    endtask
    task automatic t_lin;
        wr(PIN3_PAD_CONTROL, 32'h0000_0024);
        extOn <= 7'h00;
        sTxd <= 0;
        settle();
        chk({padOeN[1], padOut[1], sRecv}, 32'h0);
        sTxd <= 1;
        settle();
        chk({padOeN[1], sRecv}, 32'h3);
    endtask
    task automatic t_uart;
        extOn <= 7'h04;
        wr(PIN4_PAD_CONTROL, 32'h0000_0022);
        settle();
        chk(32'(uRxd), 32'h0);
        wr(PIN6_PAD_CONTROL, 32'h0000_0040);
        wr(PIN5_PAD_CONTROL, 32'h0000_0102);
        settle();
        chk({uRxd, padOeN[3]}, 32'h3);
        uBusy <= 1;
        uTxd <= 0;
        settle();
        chk({padOeN[3], padOut[3]}, 32'h0);
    endtask
    // Peripheral inputs taken from pads: MISO, UART transmit monitor, master test path.
    task automatic t_inputs;
        extOn <= 7'h2c;
        extLevel <= 7'h08;
        dbg <= 1;
        wr(PIN5_PAD_CONTROL, 32'h0000_0024);
        wr(PIN7_PAD_CONTROL, 32'h0000_0026);
        wr(PIN4_PAD_CONTROL, 32'h0000_0025);
        settle();
        chk({miso, uFromPad, mTest, mRecv}, 32'h9);
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 0;
        t_reset();
        t_mask();
        t_port();
        t_pwm();
        t_mux();
        t_lin();
        t_uart();
        t_inputs();
        close_out();
    end
    // Guard against a hang.
    initial begin
        repeat (5000) @(posedge core_clk);
        fail_count++;
        close_out();
    end
endmodule
`default_nettype wire

/* testbench/pad_partner.sv */
// Model of the board around the seven pads: an outside driver plus the pulls.
// Assumes the pad driver enable is active low and one clock domain.
`default_nettype none
module pad_partner (
    // Clock.
    input wire logic clk,
    // Device side of the pads.
    input wire logic [6:0] padOut,
    input wire logic [6:0] padOeN,
    input wire logic [6:0] padPullUpOn,
    input wire logic [6:0] padPullDownOn,
    // Outside driver and the level seen on the pads.
    input wire logic [6:0] extLevel,
    input wire logic [6:0] extOn,
    output logic [6:0] padIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] floatLevel = 7'h00;
    // A pad nobody holds wanders each cycle, so a stale level never passes for a real one.
    always @(posedge clk) floatLevel <= ~floatLevel;
    // The device driver wins, then the outside driver, then the pulls.
    assign padIn = (~padOeN & padOut) | (padOeN & extOn & extLevel) |
        (padOeN & ~extOn & (padPullUpOn | (~padPullDownOn & floatLevel)));
endmodule
`default_nettype wire
